// file: hdl/trace_level_trigger.sv
// trace level trigger: voltage and current crossing, pretrigger offset, trace buffer, output state
// assumes an avalon-mm master on clk_sys and a sample source with one-cycle valid
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "trace_level_trigger_defines.svh"
module trace_level_trigger
  import trace_level_trigger_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sampleValid,
  input wire logic [15:0] voltSample,
  input wire logic [15:0] currSample,
  output logic [1:0] outState,
  output logic triggerSeen,
  output logic irq
);

  // ****************************************
  // settings registers
  // ****************************************
  logic voltEnable_q;
  logic voltFalling_q;
  logic [15:0] voltLevel_q;
  logic currEnable_q;
  logic currFalling_q;
  logic [15:0] currLevel_q;
  logic [11:0] trigOffset_q;
  out_state_type outState_q;
  logic seen_q;
  logic [`IRQ_WIDTH-1:0] irqStatus_q;
  logic [`IRQ_WIDTH-1:0] irqEnable_q;
  logic [31:0] readdata_q;
  logic ack_q;
  logic irq_q;
  logic waitReq_q;

  // ****************************************
  // trace buffer
  // ****************************************
  logic [31:0] traceMem [0:2499];
  logic [11:0] wrPtr_q;
  logic [11:0] count_q;
  logic [11:0] wipePtr_q;
  buf_state_type bufState_q;

  // ****************************************
  // bus decode
  // ****************************************
  wire logic access = (read || write) && !ack_q;
  // write lands at the edge that sees waitrequest low
  wire logic wrStb = write && ack_q;
  wire logic hitVoltCtrl = address == `OFS_VOLT_CTRL;
  wire logic hitVoltLevel = address == `OFS_VOLT_LEVEL;
  wire logic hitCurrCtrl = address == `OFS_CURR_CTRL;
  wire logic hitCurrLevel = address == `OFS_CURR_LEVEL;
  wire logic hitOffset = address == `OFS_TRIG_OFFSET;
  wire logic hitOutState = address == `OFS_OUT_STATE;
  wire logic hitBufClear = address == `OFS_BUF_CLEAR;
  wire logic hitIrqEnable = address == `OFS_IRQ_ENABLE;
  wire logic hitIrqClear = address == `OFS_IRQ_CLEAR;
  wire logic wrVoltCtrl = wrStb && hitVoltCtrl;
  wire logic wrVoltLevel = wrStb && hitVoltLevel && writedata[15:0] <= `VOLT_LEVEL_MAX;
  wire logic wrCurrCtrl = wrStb && hitCurrCtrl;
  wire logic wrCurrLevel = wrStb && hitCurrLevel && writedata[15:0] <= `CURR_LEVEL_MAX;
  wire logic wrOffset = wrStb && hitOffset && writedata[11:0] <= `BUF_POINTS && writedata[31:12] == 20'h0;
  wire logic wrOutState = wrStb && hitOutState && writedata[1:0] != 2'b11;
  wire logic bufClear = wrStb && hitBufClear;
  wire logic settingsWrite = wrVoltCtrl || wrVoltLevel || wrCurrCtrl || wrCurrLevel || wrOffset;

  // ****************************************
  // crossing detection
  // ****************************************
  logic voltHit;
  logic currHit;
  wire logic wiping = bufState_q == ST_WIPE;
  wire logic rearm = settingsWrite || bufClear;

  level_crossing voltCross (
    .clk_sys(clk_sys),
    .rst(rst),
    .sampleValid(sampleValid),
    .sample(voltSample),
    .level(voltLevel_q),
    .enable(voltEnable_q),
    .falling(voltFalling_q),
    .rearm(rearm),
    .hit(voltHit)
  );

  level_crossing currCross (
    .clk_sys(clk_sys),
    .rst(rst),
    .sampleValid(sampleValid),
    .sample(currSample),
    .level(currLevel_q),
    .enable(currEnable_q),
    .falling(currFalling_q),
    .rearm(rearm),
    .hit(currHit)
  );

  wire logic fire = (voltHit || currHit) && !seen_q && !wiping;

  // ****************************************
  // logging and pretrigger discard
  // ****************************************
  wire logic logSample = sampleValid && !wiping && (seen_q || fire || trigOffset_q == 12'h000);
  wire logic [11:0] keepBefore = (count_q > trigOffset_q) ? count_q - trigOffset_q : 12'h000;
  wire logic [11:0] wrPtrNext = (wrPtr_q == `BUF_POINTS - 12'd1) ? 12'h000 : wrPtr_q + 12'd1;
  wire logic full = count_q == `BUF_POINTS;
  wire logic becameFull = logSample && count_q == `BUF_POINTS - 12'd1;
  wire logic [`IRQ_WIDTH-1:0] irqEvents = {becameFull, fire};

  // ****************************************
  // read mux
  // ****************************************
  wire logic [31:0] rdVal =
    hitVoltCtrl ? {30'h0, voltFalling_q, voltEnable_q} :
    hitVoltLevel ? {16'h0, voltLevel_q} :
    hitCurrCtrl ? {30'h0, currFalling_q, currEnable_q} :
    hitCurrLevel ? {16'h0, currLevel_q} :
    hitOffset ? {20'h0, trigOffset_q} :
    (address == `OFS_STATUS) ? {29'h0, wiping, !seen_q, seen_q} :
    hitOutState ? {30'h0, outState_q} :
    (address == `OFS_IRQ_STATUS) ? {30'h0, irqStatus_q} :
    hitIrqEnable ? {30'h0, irqEnable_q} :
    (address == `OFS_BUF_COUNT) ? {20'h0, count_q} :
    (hitBufClear || hitIrqClear) ? 32'h0 : `DEAD_DATA;

  // ****************************************
  // bus answer: one wait cycle then ack
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      waitReq_q <= 1'b1;
      readdata_q <= 32'h0;
    end else begin
      ack_q <= access;
      waitReq_q <= !access;
      if (access && read) begin
        readdata_q <= rdVal;
      end
    end
  end

  assign waitrequest = waitReq_q;
  assign readdata = readdata_q;

  // ****************************************
  // trigger settings
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      voltEnable_q <= 1'b0;
      voltFalling_q <= 1'b0;
      voltLevel_q <= `LEVEL_RESET;
      currEnable_q <= 1'b0;
      currFalling_q <= 1'b0;
      currLevel_q <= `LEVEL_RESET;
      trigOffset_q <= `OFFSET_RESET;
      outState_q <= OUT_OFF;
    end else begin
      if (wrVoltCtrl) begin
        voltEnable_q <= writedata[`BIT_ENABLE];
        voltFalling_q <= writedata[`BIT_FALLING];
      end
      if (wrVoltLevel) begin
        voltLevel_q <= writedata[15:0];
      end
      if (wrCurrCtrl) begin
        currEnable_q <= writedata[`BIT_ENABLE];
        currFalling_q <= writedata[`BIT_FALLING];
      end
      if (wrCurrLevel) begin
        currLevel_q <= writedata[15:0];
      end
      if (wrOffset) begin
        trigOffset_q <= writedata[11:0];
      end
      if (wrOutState) begin
        outState_q <= out_state_type'(writedata[1:0]);
      end
    end
  end

  // ****************************************
  // seen flag: fire wins over rewrite
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
    end else if (fire) begin
      seen_q <= 1'b1;
    end else if (rearm) begin
      seen_q <= 1'b0;
    end
  end

  // ****************************************
  // buffer pointers and wipe engine
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_q <= 12'h000;
      count_q <= 12'h000;
      wipePtr_q <= 12'h000;
      bufState_q <= ST_RUN;
    end else begin
      case (bufState_q)
        ST_RUN: begin
          if (bufClear) begin
            bufState_q <= ST_WIPE;
            wipePtr_q <= 12'h000;
            wrPtr_q <= 12'h000;
            count_q <= 12'h000;
          end else if (logSample) begin
            wrPtr_q <= wrPtrNext;
            if (fire) begin
              count_q <= keepBefore + 12'd1;
            end else if (!full) begin
              count_q <= count_q + 12'd1;
            end
          end
        end
        ST_WIPE: begin
          if (wipePtr_q == `BUF_POINTS - 12'd1) begin
            bufState_q <= ST_RUN;
          end else begin
            wipePtr_q <= wipePtr_q + 12'd1;
          end
        end
        default: begin
          bufState_q <= ST_RUN;
        end
      endcase
    end
  end

  // trace memory write port, no reset on the array
  always_ff @(posedge clk_sys) begin
    if (wiping) begin
      traceMem[wipePtr_q] <= 32'h0;
    end else if (logSample) begin
      traceMem[wrPtr_q] <= {voltSample, currSample};
    end
  end

  // ****************************************
  // interrupts: set wins over clear
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqStatus_q <= '0;
      irqEnable_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irqStatus_q <= (irqStatus_q & ~((wrStb && hitIrqClear) ? writedata[`IRQ_WIDTH-1:0] : '0)) | irqEvents;
      if (wrStb && hitIrqEnable) begin
        irqEnable_q <= writedata[`IRQ_WIDTH-1:0];
      end
      irq_q <= |(irqStatus_q & irqEnable_q);
    end
  end

  // ****************************************
  // wipe length counter for the checks
  // ****************************************
  logic [11:0] wipeLen_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wipeLen_q <= 12'h000;
    end else if (wiping) begin
      wipeLen_q <= wipeLen_q + 12'd1;
    end else begin
      wipeLen_q <= 12'h000;
    end
  end

  assign outState = outState_q;
  assign triggerSeen = seen_q;
  assign irq = irq_q;

  // ****************************************
  // assertions
  // ****************************************
  AST_VOLT_RESET_OFF: assert property (@(posedge clk_sys) $fell(rst) |-> !voltEnable_q)
    else $error("voltage enable not off after reset");
  AST_VOLT_LEVEL_RANGE: assert property (@(posedge clk_sys) disable iff (rst) voltLevel_q <= `VOLT_LEVEL_MAX)
    else $error("voltage level out of range");
  AST_VOLT_FIRE_DIR: assert property (@(posedge clk_sys) disable iff (rst)
    voltHit |-> (voltFalling_q ? voltSample < voltLevel_q : voltSample > voltLevel_q))
    else $error("voltage fire on wrong side");
  AST_CURR_LEVEL_RANGE: assert property (@(posedge clk_sys) disable iff (rst) currLevel_q <= `CURR_LEVEL_MAX)
    else $error("current level out of range");
  AST_CURR_ENABLE_GATE: assert property (@(posedge clk_sys) disable iff (rst) currHit |-> currEnable_q)
    else $error("current fire while disabled");
  AST_CURR_FIRE_DIR: assert property (@(posedge clk_sys) disable iff (rst)
    currHit |-> (currFalling_q ? currSample < currLevel_q : currSample > currLevel_q))
    else $error("current fire on wrong side");
  AST_OFFSET_RANGE: assert property (@(posedge clk_sys) disable iff (rst) trigOffset_q <= `BUF_POINTS)
    else $error("offset out of range");
  AST_DISCARD: assert property (@(posedge clk_sys) disable iff (rst)
    (fire && !bufClear && !wiping) |=> count_q == $past(keepBefore) + 12'd1)
    else $error("pretrigger discard wrong");
  AST_SEEN_SET: assert property (@(posedge clk_sys) disable iff (rst) fire |=> triggerSeen)
    else $error("seen flag not set");
  AST_OUT_CODE: assert property (@(posedge clk_sys) disable iff (rst) outState_q != 2'b11)
    else $error("illegal output state");
  AST_COUNT_MAX: assert property (@(posedge clk_sys) disable iff (rst) count_q <= `BUF_POINTS)
    else $error("count above buffer size");
  AST_WIPE_START: assert property (@(posedge clk_sys) disable iff (rst)
    (bufClear && !wiping) |=> wiping [*8])
    else $error("wipe did not start");
  AST_WIPE_LEN: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(wiping) |-> wipeLen_q == `BUF_POINTS)
    else $error("wipe length wrong");
  AST_WIPE_BOUND: assert property (@(posedge clk_sys) disable iff (rst)
    wiping |-> wipeLen_q < `BUF_POINTS)
    else $error("wipe longer than buffer");
  AST_SEEN_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    (seen_q && !rearm) |=> seen_q)
    else $error("seen flag dropped");

  COV_VOLT_FIRE: cover property (@(posedge clk_sys) disable iff (rst) voltHit && fire);
  COV_CURR_FALL: cover property (@(posedge clk_sys) disable iff (rst) currHit && currFalling_q);
  COV_WIPE: cover property (@(posedge clk_sys) disable iff (rst) bufClear ##1 wiping);
  COV_IRQ: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));

endmodule : trace_level_trigger

// file: hdl/trace_level_trigger_defines.svh
// constants for the trace level trigger: register offsets, field positions, resets, limits
// assumes a 32-bit avalon-mm slave with word addressing in bytes
`ifndef TRACE_LEVEL_TRIGGER_DEFINES_SVH
`define TRACE_LEVEL_TRIGGER_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_VOLT_CTRL 6'h00
`define OFS_VOLT_LEVEL 6'h04
`define OFS_CURR_CTRL 6'h08
`define OFS_CURR_LEVEL 6'h0c
`define OFS_TRIG_OFFSET 6'h10
`define OFS_STATUS 6'h14
`define OFS_OUT_STATE 6'h18
`define OFS_BUF_CLEAR 6'h1c
`define OFS_IRQ_STATUS 6'h20
`define OFS_IRQ_ENABLE 6'h24
`define OFS_IRQ_CLEAR 6'h28
`define OFS_BUF_COUNT 6'h2c

// ****************************************
// field positions
// ****************************************
`define BIT_ENABLE 0
`define BIT_FALLING 1
`define BIT_SEEN 0
`define BIT_ARMED 1
`define IRQ_TRIGGER 0
`define IRQ_FULL 1
`define IRQ_WIDTH 2

// ****************************************
// resets and limits (millivolt, milliampere, points)
// ****************************************
`define VOLT_LEVEL_MAX 16'd20000
`define CURR_LEVEL_MAX 16'd6000
`define BUF_POINTS 12'd2500
`define LEVEL_RESET 16'h0000
`define OFFSET_RESET 12'h000
`define DEAD_DATA 32'hdead_beef

`endif

// file: hdl/trace_level_trigger_pkg.sv
// types shared by the trace level trigger files
// assumes the defines header sits beside it
package trace_level_trigger_pkg;

  // ****************************************
  // output state and clear engine states
  // ****************************************
  typedef enum logic [1:0] {
    OUT_OFF = 2'b00,
    OUT_ON = 2'b01,
    OUT_DISABLE = 2'b10
  } out_state_type;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_WIPE = 1'b1
  } buf_state_type;

endpackage : trace_level_trigger_pkg

// file: hdl/level_crossing.sv
// one channel of threshold crossing detection
// assumes samples arrive with a one-cycle valid strobe on clk_sys
`timescale 1ns/1ps
module level_crossing (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sampleValid,
  input wire logic [15:0] sample,
  input wire logic [15:0] level,
  input wire logic enable,
  input wire logic falling,
  input wire logic rearm,
  output logic hit
);

  logic prevAbove_q;
  logic prevKnown_q;
  wire logic above = sample > level;
  wire logic below = sample < level;
  wire logic wasAbove = prevAbove_q;

  // crossing only from a known previous side
  assign hit = sampleValid && enable && prevKnown_q &&
               (falling ? (wasAbove && below) : (!wasAbove && above));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prevAbove_q <= 1'b0;
      prevKnown_q <= 1'b0;
    end else if (rearm) begin
      prevKnown_q <= 1'b0;
    end else if (sampleValid) begin
      prevAbove_q <= above;
      prevKnown_q <= 1'b1;
    end
  end

endmodule : level_crossing

// file: tb/sample_source.sv
// measurement side model: drives voltage and current samples with a one-cycle valid per sample
// assumes clk_sys from the bench; samples change just after a rising edge
`timescale 1ns/1ps
module sample_source (
  input wire logic clk_sys,
  output logic sampleValid,
  output logic [15:0] voltSample,
  output logic [15:0] currSample
);
  // ****************************************
  // sample driver
  // ****************************************
  initial begin
    {sampleValid, voltSample, currSample} = {1'b0, 16'h0000, 16'h0000};
  end

  // n back-to-back samples of one value, then lines show the inverse so stale data never looks valid
  task automatic send(input logic [15:0] v, input logic [15:0] c, input int n);
    @(posedge clk_sys);
    {sampleValid, voltSample, currSample} <= {1'b1, v, c};
    repeat (n) @(posedge clk_sys);
    {sampleValid, voltSample, currSample} <= {1'b0, ~v, ~c};
  endtask : send
endmodule : sample_source

// file: tb/tb.sv
// self-checking bench for trace_level_trigger: avalon-mm tasks and one task per scenario
// assumes sample_source on the measurement side and the defines header on the include path
`timescale 1ns/1ps
`include "trace_level_trigger_defines.svh"
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest, sampleValid, triggerSeen, irq;
  logic [15:0] voltSample, currSample;
  logic [1:0] outState;
  int n_errors = 0;
  int checks = 0;

  always #5 clk_sys = ~clk_sys;

  trace_level_trigger i_trace_level_trigger (.clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sampleValid(sampleValid), .voltSample(voltSample), .currSample(currSample), .outState(outState),
    .triggerSeen(triggerSeen), .irq(irq));
  sample_source i_sample_source (.clk_sys(clk_sys), .sampleValid(sampleValid), .voltSample(voltSample),
    .currSample(currSample));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    {address, writedata, write, read} <= {a, d, wr, ~wr};
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    q = readdata;
    {write, read} <= 2'b00;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask : settle

  task automatic src(input logic [15:0] v, input logic [15:0] c, input int n);
    i_sample_source.send(v, c, n);
  endtask : src

  task automatic wipe;
    logic [31:0] q;
    q = 32'h4;
    wr(`OFS_BUF_CLEAR, 32'h1);
    rd(`OFS_STATUS, 32'h6, "statusWiping");
    for (int i = 0; i < 1000 && q[2] !== 1'b0; i++) bus(1'b0, `OFS_STATUS, 32'h0, q);
    chk("wipeDone", 32'h0, {31'h0, q[2]});
    rd(`OFS_BUF_COUNT, 32'h0, "countAfterClear");
  endtask : wipe

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(`OFS_VOLT_CTRL, 32'h0, "voltCtrl");
    rd(`OFS_VOLT_LEVEL, 32'h0, "voltLevel");
    rd(`OFS_CURR_CTRL, 32'h0, "currCtrl");
    rd(`OFS_CURR_LEVEL, 32'h0, "currLevel");
    rd(`OFS_TRIG_OFFSET, 32'h0, "offset");
    rd(`OFS_OUT_STATE, 32'h0, "outStateReg");
    rd(`OFS_STATUS, 32'h2, "status");
    rd(6'h30, `DEAD_DATA, "unmapped");
    chk("outState", 32'h0, {30'h0, outState});
  endtask : t_reset

  task automatic t_ranges;
    wr(`OFS_VOLT_LEVEL, 32'h0000_4e20);
    wr(`OFS_VOLT_LEVEL, 32'h0000_4e21);
    rd(`OFS_VOLT_LEVEL, 32'h0000_4e20, "voltLevelMax");
    wr(`OFS_CURR_LEVEL, 32'h0000_1770);
    wr(`OFS_CURR_LEVEL, 32'h0000_1771);
    rd(`OFS_CURR_LEVEL, 32'h0000_1770, "currLevelMax");
    wr(`OFS_TRIG_OFFSET, 32'h0000_09c4);
    wr(`OFS_TRIG_OFFSET, 32'h0000_09c5);
    rd(`OFS_TRIG_OFFSET, 32'h0000_09c4, "offsetMax");
    for (int s = 0; s < 4; s++) begin
      wr(`OFS_OUT_STATE, 32'(s));
      settle();
      chk("outState", (s == 3) ? 32'h2 : 32'(s), {30'h0, outState});
    end
    wr(`OFS_OUT_STATE, 32'h0);
    wr(`OFS_TRIG_OFFSET, 32'h0);
  endtask : t_ranges

  task automatic t_volt;
    wr(`OFS_VOLT_LEVEL, 32'h0000_03e8);
    wr(`OFS_CURR_LEVEL, 32'h0);
    wr(`OFS_IRQ_ENABLE, 32'h1);
    src(16'd500, 16'd0, 1);
    src(16'd1500, 16'd100, 1);
    settle();
    chk("seenDisabled", 32'h0, {31'h0, triggerSeen});
    wr(`OFS_VOLT_CTRL, 32'h1);
    src(16'd500, 16'd0, 1);
    src(16'd1500, 16'd0, 1);
    settle();
    chk("seenRise", 32'h1, {31'h0, triggerSeen});
    chk("irqRise", 32'h1, {31'h0, irq});
    rd(`OFS_STATUS, 32'h1, "statusSeen");
    wr(`OFS_IRQ_CLEAR, 32'h1);
    settle();
    chk("irqCleared", 32'h0, {31'h0, irq});
    rd(`OFS_IRQ_CLEAR, 32'h0, "irqClearReg");
    chk("seenHeld", 32'h1, {31'h0, triggerSeen});
    wr(`OFS_IRQ_ENABLE, 32'h0);
    wr(`OFS_VOLT_CTRL, 32'h3);
    src(16'd500, 16'd0, 1);
    src(16'd1500, 16'd0, 1);
    settle();
    chk("seenFallNoRise", 32'h0, {31'h0, triggerSeen});
    src(16'd500, 16'd0, 1);
    settle();
    chk("seenFall", 32'h1, {31'h0, triggerSeen});
    chk("irqMasked", 32'h0, {31'h0, irq});
    rd(`OFS_IRQ_STATUS, 32'h1, "irqStatus");
    wr(`OFS_IRQ_CLEAR, 32'h1);
    wr(`OFS_VOLT_CTRL, 32'h0);
  endtask : t_volt

  task automatic t_curr;
    wr(`OFS_CURR_LEVEL, 32'h0000_07d0);
    wr(`OFS_CURR_CTRL, 32'h3);
    src(16'd0, 16'd3000, 1);
    src(16'd0, 16'd1000, 1);
    settle();
    chk("seenCurrFall", 32'h1, {31'h0, triggerSeen});
    wr(`OFS_CURR_CTRL, 32'h3);
    settle();
    chk("seenRewrite", 32'h0, {31'h0, triggerSeen});
    wr(`OFS_CURR_CTRL, 32'h0);
    wr(`OFS_IRQ_CLEAR, 32'h1);
  endtask : t_curr

  task automatic t_fill;
    wipe();
    wr(`OFS_IRQ_ENABLE, 32'h2);
    src(16'd100, 16'd200, 2499);
    settle();
    rd(`OFS_IRQ_STATUS, 32'h0, "notFull");
    src(16'd100, 16'd200, 1);
    settle();
    rd(`OFS_BUF_COUNT, 32'h0000_09c4, "countFull");
    rd(`OFS_IRQ_STATUS, 32'h2, "irqFull");
    chk("irqFullPin", 32'h1, {31'h0, irq});
    wr(`OFS_IRQ_CLEAR, 32'h2);
    settle();
    chk("irqFullCleared", 32'h0, {31'h0, irq});
    wipe();
  endtask : t_fill

  task automatic t_offset;
    src(16'd100, 16'd0, 20);
    settle();
    rd(`OFS_BUF_COUNT, 32'h0000_0014, "countFree");
    wr(`OFS_TRIG_OFFSET, 32'h0000_000a);
    wr(`OFS_VOLT_CTRL, 32'h1);
    src(16'd100, 16'd0, 1);
    src(16'd1500, 16'd0, 1);
    settle();
    chk("seenOffset", 32'h1, {31'h0, triggerSeen});
    rd(`OFS_BUF_COUNT, 32'h0000_000b, "countOffset");
  endtask : t_offset

  // ****************************************
  // run control
  // ****************************************
  task automatic close_out;
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_ranges();
    t_volt();
    t_curr();
    t_fill();
    t_offset();
    close_out();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
endmodule : tb
